// >>> tb/modbus_master_model.sv
// Behavioural line master: sends query bytes, collects reply bytes
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model (
  input wire logic mclk,
  output logic rxValid,
  output logic [7:0] rxData,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady
);
  logic [7:0] got[$];
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    txReady = 1'b0;
  end
  // Random stalls keep the two-entry buffer under pressure
  always @(posedge mclk) begin
    if (txValid && txReady) got.push_back(txData);
    #1 txReady <= ($urandom % 4) != 0;
  end
  task send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(posedge mclk);
      #1 rxValid = 1'b1;
      rxData = q[i];
    end
    @(posedge mclk);
    #1 rxValid = 1'b0;
    rxData = ~rxData; // Released line shows no stale byte
  endtask
endmodule
`default_nettype wire

// >>> tb/modbus_rtu_slave_query_engine_test.sv
// Self-checking bench for the serial-link slave query engine
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_slave_query_engine_test;
  localparam logic [16:0] SIL = 17'h00014;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] stationAddressSetting = 8'h11;
  logic [15:0] installedCoils = 16'h0800;
  logic resourceBusy = 1'b0, wrongState = 1'b0, settingsLocked = 1'b0;
  logic rxValid, txValid, txReady, txActive, coilBit;
  logic [7:0] rxData, txData;
  logic [15:0] coilAddr, invalidAddrCount, illegalRegCount, badFormatCount;
  logic [63:0] coilMap;
  integer num_errors = 0, compares = 0, expA = 0, expR = 0, expF = 0, i;
  logic [7:0] q[$], e[$];
  always #10 mclk = ~mclk;
  assign coilBit = coilMap[coilAddr[5:0]];
  modbus_rtu_slave_query_engine #(.SILENCE_CYCLES(SIL)) uut (.mclk, .rst, .stationAddressSetting,
    .rxValid, .rxData, .txValid, .txData, .txReady, .txActive, .coilAddr, .coilBit,
    .installedCoils, .resourceBusy, .wrongState, .settingsLocked, .invalidAddrCount,
    .illegalRegCount, .badFormatCount);
  modbus_master_model master (.mclk, .rxValid, .rxData, .txValid, .txData, .txReady);
  task check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic seal(ref logic [7:0] d[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (d[k]) begin
      c = c ^ {8'h00, d[k]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    d.push_back(c[7:0]);
    d.push_back(c[15:8]);
  endtask
  task automatic run(input logic [7:0] adr, fn, input logic [15:0] st, n, input int mode);
    logic [7:0] x;
    int k;
    q = {adr, fn, st[15:8], st[7:0], n[15:8], n[7:0]};
    if (mode == 2) q.pop_back();
    seal(q);
    if (mode == 1) q[$] = q[$] ^ 8'h01;
    e = {};
    x = 8'h00;
    if (adr == stationAddressSetting && mode != 1) begin
      if (!(fn inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h10, 8'h60, 8'h61,
          8'h62, 8'h7d})) x = 8'h01;
      else if (resourceBusy) x = 8'h06;
      else if (wrongState) x = 8'h04;
      else if (settingsLocked && fn inside {8'h05, 8'h06, 8'h10}) x = 8'h02;
      else if (fn != 8'h01) x = 8'h04;
      else if (mode == 2) begin
        x = 8'h03;
        expF++;
      end else if (n == 16'h0000 || n > 16'd2000) begin
        x = 8'h03;
        expR++;
      end else if ({1'b0, st} + n > installedCoils) begin
        x = 8'h02;
        expA++;
      end
      e = {adr, x == 8'h00 ? fn : fn | 8'h80};
      if (x != 8'h00) e.push_back(x);
      else begin
        e.push_back(8'((n + 16'h0007) / 16'h0008));
        for (k = 0; k < n; k++) begin
          x[k % 8] = coilMap[(st + k) % 64];
          if (k % 8 == 7 || k == n - 1) begin
            e.push_back(x);
            x = 8'h00;
          end
        end
      end
      seal(e);
    end
    master.got = {};
    master.send(q);
    repeat (SIL + 5) @(posedge mclk);
    k = 0;
    while (txActive !== 1'b0 && k < 9000) begin
      @(posedge mclk);
      k++;
    end
    repeat (3) @(posedge mclk);
    check(16'(txActive), 16'h0000);
    check(16'(master.got.size()), 16'(e.size()));
    foreach (e[j]) check(16'(master.got[j]), 16'(e[j]));
    check(invalidAddrCount, 16'(expA));
    check(illegalRegCount, 16'(expR));
    check(badFormatCount, 16'(expF));
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #(20 * 100000);
    num_errors++;
    end_of_test;
  end
  initial begin
    void'($urandom(39));
    coilMap = {$urandom, $urandom};
    repeat (16) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (6) run(stationAddressSetting, 8'h01, 16'($urandom % 1000), 16'(1 + $urandom % 200), 0);
    $display("random coil reads done");
    run(stationAddressSetting, 8'h01, 16'h0000, 16'd2000, 0);
    run(stationAddressSetting, 8'h01, 16'h0000, 16'd2001, 0);
    run(stationAddressSetting, 8'h01, 16'h0000, 16'h0000, 0);
    run(stationAddressSetting, 8'h01, 16'h07f8, 16'h0008, 0);
    run(stationAddressSetting, 8'h01, 16'h07f8, 16'h0009, 0);
    run(stationAddressSetting, 8'h01, 16'h0000, 16'h0008, 2);
    $display("coil limits done");
    run(stationAddressSetting, 8'h01, 16'h0000, 16'h0008, 1);
    run(stationAddressSetting ^ 8'h01, 8'h01, 16'h0000, 16'h0008, 0);
    run(8'h00, 8'h01, 16'h0000, 16'h0008, 0);
    $display("dropped frames done");
    for (i = 0; i < 256; i++) run(stationAddressSetting, 8'(i), 16'h0000, 16'h0008, 0);
    for (i = 0; i < 3; i++) begin
      #1 {resourceBusy, wrongState, settingsLocked} = 3'b100 >> i;
      run(stationAddressSetting, 8'h06, 16'h0000, 16'h0001, 0);
    end
    #1 {resourceBusy, wrongState, settingsLocked} = 3'b000;
    $display("function codes done");
    q = {stationAddressSetting, 8'h01, 8'h00, 8'h00, 8'h07, 8'hd0};
    seal(q);
    master.send(q);
    repeat (SIL + 40) @(posedge mclk);
    #1 rst = 1'b1;
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    check(16'({txValid, txActive}), 16'h0000);
    check(badFormatCount, 16'h0000);
    check(invalidAddrCount, 16'h0000);
    check(illegalRegCount, 16'h0000);
    check(coilAddr, 16'h0000);
    check(16'(txData), 16'h0000);
    expA = 0;
    expR = 0;
    expF = 0;
    run(stationAddressSetting, 8'h01, 16'h0003, 16'h000b, 0);
    $display("mid-run reset done");
    end_of_test;
  end
endmodule
`default_nettype wire

// >>> tb/query_engine_asserts.sv
// Checker for the serial-link slave query engine
`timescale 1ns/1ps
`default_nettype none
module query_engine_checker #(
  parameter [16:0] SILENCE_CYCLES = 17'h00014
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] stationAddressSetting,
  input wire logic rxValid,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txReady,
  input wire logic txActive,
  input wire logic [15:0] badFormatCount
);
  reg [16:0] idle;
  reg [8:0] idx;
  reg [7:0] fn;
  reg [7:0] n;
  always @(posedge mclk) begin
    if (rst || rxValid) idle <= 17'h00000;
    else if (idle != 17'h1ffff) idle <= idle + 17'h00001;
    if (rst || !txActive) idx <= 9'h000;
    else if (txValid && txReady) idx <= idx + 9'h001;
    if (txValid && txReady && idx == 9'h001) fn <= txData;
    if (txValid && txReady && idx == 9'h002) n <= txData;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_stall_holds_byte: assert property (
    txValid && !txReady |=> txValid && $stable(txData)) else $error("byte lost in stall");
  a_silent_while_rx: assert property (
    rxValid |-> !txActive) else $error("engine active while master sends");
  a_wait_for_silence: assert property (
    $rose(txActive) |-> idle >= SILENCE_CYCLES - 17'h00002) else $error("reply before silence");
  a_first_is_station: assert property (
    txValid && idx == 9'h000 |-> txData == stationAddressSetting) else $error("bad address byte");
  a_exc_code_known: assert property (
    txValid && idx == 9'h002 && fn[7] |-> txData inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h06})
    else $error("unknown exception code");
  a_exc_len_five: assert property (
    $fell(txActive) && idx != 9'h000 && fn[7] |-> idx == 9'h005) else $error("bad error length");
  a_coil_reply_len: assert property (
    $fell(txActive) && idx != 9'h000 && fn == 8'h01 |-> idx == {1'b0, n} + 9'h005)
    else $error("bad coil reply length");
  a_count_step_one: assert property (
    $changed(badFormatCount) |-> badFormatCount == $past(badFormatCount) + 16'h0001)
    else $error("counter jumped");
endmodule
bind modbus_rtu_slave_query_engine query_engine_checker #(.SILENCE_CYCLES(SILENCE_CYCLES)) chk (
  .mclk, .rst, .stationAddressSetting, .rxValid, .txValid, .txData, .txReady, .txActive,
  .badFormatCount);
`default_nettype wire

// >>> verilog/modbus_map.vh
// Constants for the serial-link slave query engine
`ifndef MODBUS_MAP_VH
`define MODBUS_MAP_VH

`define CLK_MHZ 50
`define SILENCE_US 2005
`define SILENCE_CYCLES (`SILENCE_US * `CLK_MHZ)
`define SILENCE_W 17

`define MIN_FRAME 9'h004
`define MAX_FRAME 9'h0ff
`define HDR_BYTES 6
`define COIL_QUERY_LEN 9'h008
`define MAX_COILS 17'h007d0

`define CRC_INIT 16'hffff
`define CRC_POLY 16'ha001
`define CRC_RESIDUE 16'h0000

`define FN_READ_COILS 8'h01
`define FN_READ_INPUTS 8'h02
`define FN_READ_HOLDING 8'h03
`define FN_READ_INPUT_REGS 8'h04
`define FN_FORCE_COIL 8'h05
`define FN_PRESET_REG 8'h06
`define FN_DIAG 8'h08
`define FN_PRESET_MULTI 8'h10
`define FN_PARAM_INFO 8'h60
`define FN_PARAM_TEXT 8'h61
`define FN_ENUM_TEXT 8'h62
`define FN_ENCAP 8'h7d
`define FN_NOP 8'h7e

`define EXC_FLAG 8'h80
`define EXC_ILLEGAL_FUNC 8'h01
`define EXC_ILLEGAL_ADDR 8'h02
`define EXC_ILLEGAL_VALUE 8'h03
`define EXC_DEVICE_ERROR 8'h04
`define EXC_BUSY 8'h06

`endif

// >>> verilog/modbus_rtu_slave_query_engine.v
// Serial-link slave query engine: frame check, decode, coil read, exception replies
`timescale 1ns/1ps
`default_nettype none
`include "modbus_map.vh"

module modbus_rtu_slave_query_engine #(
  parameter [`SILENCE_W-1:0] SILENCE_CYCLES = `SILENCE_CYCLES
) (
  input wire mclk,
  input wire rst,
  input wire [7:0] stationAddressSetting,
  input wire rxValid,
  input wire [7:0] rxData,
  output wire txValid,
  output wire [7:0] txData,
  input wire txReady,
  output wire txActive,
  output reg [15:0] coilAddr,
  input wire coilBit,
  input wire [15:0] installedCoils,
  input wire resourceBusy,
  input wire wrongState,
  input wire settingsLocked,
  output reg [15:0] invalidAddrCount,
  output reg [15:0] illegalRegCount,
  output reg [15:0] badFormatCount
);

  localparam [2:0] ST_RX = 3'h0;
  localparam [2:0] ST_EVAL = 3'h1;
  localparam [2:0] ST_HDR = 3'h2;
  localparam [2:0] ST_FETCH = 3'h3;
  localparam [2:0] ST_SAMPLE = 3'h4;
  localparam [2:0] ST_PUSH = 3'h5;
  localparam [2:0] ST_CRC_LO = 3'h6;
  localparam [2:0] ST_CRC_HI = 3'h7;

  function [15:0] crcByte;
    input [15:0] crcIn;
    input [7:0] dataIn;
    integer i;
    reg [15:0] x;
    begin
      x = crcIn ^ {8'h00, dataIn};
      for (i = 0; i < 8; i = i + 1) begin
        if (x[0]) begin
          x = (x >> 1) ^ `CRC_POLY;
        end else begin
          x = x >> 1;
        end
      end
      crcByte = x;
    end
  endfunction

  reg [2:0] state_reg;
  reg [7:0] hdr_reg [0:`HDR_BYTES-1];
  reg [8:0] rxCount_reg;
  reg [15:0] rxCrc_reg;
  reg [`SILENCE_W-1:0] silence_reg;
  reg isExc_reg;
  reg [7:0] excCode_reg;
  reg [7:0] byteCount_reg;
  reg [7:0] bytesLeft_reg;
  reg [1:0] hdrIdx_reg;
  reg [10:0] bitIdx_reg;
  reg [2:0] bitPos_reg;
  reg [7:0] shift_reg;
  reg [15:0] txCrc_reg;
  reg [7:0] pushData;
  reg pushValid;
  wire pushReady;
  wire pushFire;
  wire frameEnd;
  wire [7:0] funcCode;
  wire [15:0] startAddr;
  wire [15:0] bitCount;
  wire [16:0] endAddr;
  wire [10:0] bitCount11;
  reg supported;
  wire isWrite;
  wire crcGood;
  wire addrMatch;

  assign funcCode = hdr_reg[1];
  assign startAddr = {hdr_reg[2], hdr_reg[3]};
  assign bitCount = {hdr_reg[4], hdr_reg[5]};
  // Zero-based addressing: last coil is start + count - 1
  assign endAddr = {1'b0, startAddr} + {1'b0, bitCount};
  assign bitCount11 = bitCount[10:0];
  assign crcGood = (rxCrc_reg == `CRC_RESIDUE);
  assign addrMatch = (hdr_reg[0] == stationAddressSetting);
  assign isWrite = (funcCode == `FN_FORCE_COIL) || (funcCode == `FN_PRESET_REG) ||
                   (funcCode == `FN_PRESET_MULTI);
  assign frameEnd = (state_reg == ST_RX) && (rxCount_reg != 9'h000) &&
                    (silence_reg >= SILENCE_CYCLES - 1'b1);
  assign pushFire = pushValid && pushReady;
  // Line stays claimed until the last reply byte has left the buffer
  assign txActive = (state_reg != ST_RX) || txValid;

  // Stand-alone 7Eh falls to unsupported
  always @* begin
    case (funcCode)
      `FN_READ_COILS, `FN_READ_INPUTS, `FN_READ_HOLDING, `FN_READ_INPUT_REGS,
      `FN_FORCE_COIL, `FN_PRESET_REG, `FN_DIAG, `FN_PRESET_MULTI,
      `FN_PARAM_INFO, `FN_PARAM_TEXT, `FN_ENUM_TEXT, `FN_ENCAP: begin
        supported = 1'b1;
      end
      default: begin
        supported = 1'b0;
      end
    endcase
  end

  always @* begin
    pushValid = 1'b0;
    pushData = 8'h00;
    case (state_reg)
      ST_HDR: begin
        pushValid = 1'b1;
        if (hdrIdx_reg == 2'h0) begin
          pushData = stationAddressSetting;
        end else if (hdrIdx_reg == 2'h1) begin
          pushData = isExc_reg ? (funcCode | `EXC_FLAG) : funcCode;
        end else begin
          pushData = isExc_reg ? excCode_reg : byteCount_reg;
        end
      end
      ST_PUSH: begin
        pushValid = 1'b1;
        pushData = shift_reg;
      end
      ST_CRC_LO: begin
        pushValid = 1'b1;
        pushData = txCrc_reg[7:0];
      end
      ST_CRC_HI: begin
        pushValid = 1'b1;
        pushData = txCrc_reg[15:8];
      end
      default: begin
        pushValid = 1'b0;
        pushData = 8'h00;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      state_reg <= ST_RX;
      hdr_reg[0] <= 8'h00;
      hdr_reg[1] <= 8'h00;
      hdr_reg[2] <= 8'h00;
      hdr_reg[3] <= 8'h00;
      hdr_reg[4] <= 8'h00;
      hdr_reg[5] <= 8'h00;
      rxCount_reg <= 9'h000;
      rxCrc_reg <= `CRC_INIT;
      silence_reg <= {`SILENCE_W{1'b0}};
      isExc_reg <= 1'b0;
      excCode_reg <= 8'h00;
      byteCount_reg <= 8'h00;
      bytesLeft_reg <= 8'h00;
      hdrIdx_reg <= 2'h0;
      bitIdx_reg <= 11'h000;
      bitPos_reg <= 3'h0;
      shift_reg <= 8'h00;
      txCrc_reg <= `CRC_INIT;
      coilAddr <= 16'h0000;
      invalidAddrCount <= 16'h0000;
      illegalRegCount <= 16'h0000;
      badFormatCount <= 16'h0000;
    end else begin
      // Check bytes must not feed the running value, or the high byte goes out wrong
      if (pushFire && state_reg != ST_CRC_LO && state_reg != ST_CRC_HI) begin
        txCrc_reg <= crcByte(txCrc_reg, pushData);
      end
      case (state_reg)
        ST_RX: begin
          if (rxValid) begin
            silence_reg <= {`SILENCE_W{1'b0}};
            if (rxCount_reg < `HDR_BYTES) begin
              hdr_reg[rxCount_reg[2:0]] <= rxData;
            end
            // Saturate so an overlong frame still reads as malformed
            if (rxCount_reg <= `MAX_FRAME) begin
              rxCount_reg <= rxCount_reg + 9'h001;
            end
            rxCrc_reg <= crcByte(rxCrc_reg, rxData);
          end else if (frameEnd) begin
            state_reg <= ST_EVAL;
          end else if (rxCount_reg != 9'h000) begin
            silence_reg <= silence_reg + 1'b1;
          end
        end
        ST_EVAL: begin
          rxCount_reg <= 9'h000;
          rxCrc_reg <= `CRC_INIT;
          silence_reg <= {`SILENCE_W{1'b0}};
          txCrc_reg <= `CRC_INIT;
          hdrIdx_reg <= 2'h0;
          bitIdx_reg <= 11'h000;
          bitPos_reg <= 3'h0;
          shift_reg <= 8'h00;
          isExc_reg <= 1'b1;
          byteCount_reg <= 8'h00;
          state_reg <= ST_HDR;
          if (rxCount_reg < `MIN_FRAME || !crcGood || !addrMatch) begin
            state_reg <= ST_RX;
          end else if (!supported) begin
            excCode_reg <= `EXC_ILLEGAL_FUNC;
          end else if (resourceBusy) begin
            excCode_reg <= `EXC_BUSY;
          end else if (wrongState) begin
            excCode_reg <= `EXC_DEVICE_ERROR;
          end else if (isWrite && settingsLocked) begin
            excCode_reg <= `EXC_ILLEGAL_ADDR;
          end else if (funcCode == `FN_READ_COILS) begin
            if (rxCount_reg != `COIL_QUERY_LEN) begin
              excCode_reg <= `EXC_ILLEGAL_VALUE;
              badFormatCount <= badFormatCount + 16'h0001;
            end else if (bitCount == 16'h0000 || {1'b0, bitCount} > `MAX_COILS) begin
              excCode_reg <= `EXC_ILLEGAL_VALUE;
              illegalRegCount <= illegalRegCount + 16'h0001;
            end else if (endAddr > {1'b0, installedCoils}) begin
              excCode_reg <= `EXC_ILLEGAL_ADDR;
              invalidAddrCount <= invalidAddrCount + 16'h0001;
            end else begin
              isExc_reg <= 1'b0;
              excCode_reg <= 8'h00;
              byteCount_reg <= bitCount11[10:3] + {7'h00, (bitCount11[2:0] != 3'h0)};
              bytesLeft_reg <= bitCount11[10:3] + {7'h00, (bitCount11[2:0] != 3'h0)};
            end
          end else begin
            // Data paths of the other functions live outside this engine
            excCode_reg <= `EXC_DEVICE_ERROR;
          end
        end
        ST_HDR: begin
          if (pushFire) begin
            hdrIdx_reg <= hdrIdx_reg + 2'h1;
            if (hdrIdx_reg == 2'h2) begin
              state_reg <= isExc_reg ? ST_CRC_LO : ST_FETCH;
            end
          end
        end
        ST_FETCH: begin
          coilAddr <= startAddr + {5'h00, bitIdx_reg};
          state_reg <= ST_SAMPLE;
        end
        ST_SAMPLE: begin
          // Bits past the request are forced low rather than read
          if (bitIdx_reg < bitCount11) begin
            shift_reg[bitPos_reg] <= coilBit;
          end else begin
            shift_reg[bitPos_reg] <= 1'b0;
          end
          bitIdx_reg <= bitIdx_reg + 11'h001;
          bitPos_reg <= bitPos_reg + 3'h1;
          state_reg <= (bitPos_reg == 3'h7) ? ST_PUSH : ST_FETCH;
        end
        ST_PUSH: begin
          if (pushFire) begin
            shift_reg <= 8'h00;
            bytesLeft_reg <= bytesLeft_reg - 8'h01;
            state_reg <= (bytesLeft_reg == 8'h01) ? ST_CRC_LO : ST_FETCH;
          end
        end
        ST_CRC_LO: begin
          if (pushFire) begin
            state_reg <= ST_CRC_HI;
          end
        end
        ST_CRC_HI: begin
          if (pushFire) begin
            state_reg <= ST_RX;
          end
        end
        default: begin
          state_reg <= ST_RX;
        end
      endcase
    end
  end

  reply_buffer replyBuf (
    .mclk(mclk),
    .rst(rst),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(txValid),
    .outReady(txReady),
    .outData(txData)
  );

endmodule

`default_nettype wire

// >>> verilog/reply_buffer.v
// Two-entry byte buffer between reply builder and line transmitter
`timescale 1ns/1ps
`default_nettype none

module reply_buffer (
  input wire mclk,
  input wire rst,
  input wire inValid,
  output wire inReady,
  input wire [7:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [7:0] outData
);

  reg [7:0] mem_reg [0:1];
  reg wrPtr_reg;
  reg rdPtr_reg;
  reg [1:0] fill_reg;
  wire doPush;
  wire doPop;

  assign inReady = (fill_reg != 2'h2);
  assign outValid = (fill_reg != 2'h0);
  assign outData = mem_reg[rdPtr_reg];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  always @(posedge mclk) begin
    if (rst) begin
      mem_reg[0] <= 8'h00;
      mem_reg[1] <= 8'h00;
      wrPtr_reg <= 1'b0;
      rdPtr_reg <= 1'b0;
      fill_reg <= 2'h0;
    end else begin
      if (doPush) begin
        mem_reg[wrPtr_reg] <= inData;
        wrPtr_reg <= ~wrPtr_reg;
      end
      if (doPop) begin
        rdPtr_reg <= ~rdPtr_reg;
      end
      if (doPush && !doPop) begin
        fill_reg <= fill_reg + 2'h1;
      end else if (doPop && !doPush) begin
        fill_reg <= fill_reg - 2'h1;
      end
    end
  end

endmodule

`default_nettype wire
